/* dv/fdc_read_cmd_chk.sv */
// Purpose: Port checks for the read/verify command interpreter
// Assumes: One clock, asynchronous active-low reset
// Notes: Only the first command byte is kept; it alone picks the operation
`timescale 1ns/1ps
`include "fdc_cmd_regs.vh"
module fdc_read_cmd_chk #(
	parameter [7:0] VERSION_CODE = 8'ha5
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Host side
	input wire cmd_valid,
	input wire [7:0] cmd_data,
	input wire cmd_ready,
	input wire host_data_valid,
	input wire res_valid,
	input wire [7:0] res_data,
	input wire res_rd,
	input wire phase_execution,
	// Read path side
	input wire exec_start,
	input wire [2:0] exec_op,
	input wire skip_marked_sectors,
	input wire rd_data_valid,
	input wire rd_data_deleted,
	input wire rd_data_ready,
	input wire rd_done,
	input wire [7:0] result_status_0
);
reg [3:0] cnt;
reg [2:0] pops;
reg ran;
reg [7:0] b1;
reg [7:0] s0;
wire take = cmd_valid && cmd_ready;
wire [2:0] want_op = b1[4:0] == `CODE_READ_DELETED ? `OP_READ_DELETED :
	b1[4:0] == `CODE_VERIFY ? `OP_VERIFY :
	b1[5:0] == `CODE_READ_ID ? `OP_READ_ID : `OP_READ_TRACK;
always @(posedge sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		cnt <= 4'h0;
		pops <= 3'h0;
		ran <= 1'b0;
	end else begin
		cnt <= take ? cnt + 4'h1 : (cmd_ready ? cnt : 4'h0);
		pops <= take ? 3'h0 : pops + {2'h0, res_valid & res_rd};
		ran <= exec_start | (ran & ~take);
	end
end
always @(posedge sys_clk) begin
	if (take && cnt == 4'h0)
		b1 <= cmd_data;
	if (rd_done)
		s0 <= result_status_0;
end
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
property p_start; exec_start |-> phase_execution && !cmd_ready && !res_valid;
endproperty
a_start: assert property (p_start) else $error("start out of phase");
property p_pulse; exec_start |=> !exec_start;
endproperty
a_pulse: assert property (p_pulse) else $error("start too long");
property p_result; res_valid |-> !cmd_ready && !phase_execution;
endproperty
a_result: assert property (p_result) else $error("phase overlap");
property p_op; exec_start |-> exec_op == want_op;
endproperty
a_op: assert property (p_op) else $error("bad op");
property p_version; take && cnt == 4'h0 && cmd_data == `CODE_VERSION
	|=> res_valid && res_data == VERSION_CODE && !exec_start;
endproperty
a_version: assert property (p_version) else $error("bad version");
property p_count; $fell(res_valid) |-> pops == (ran ? 3'h7 : 3'h1);
endproperty
a_count: assert property (p_count) else $error("bad count");
property p_status; $rose(res_valid) && ran |-> res_data == s0;
endproperty
a_status: assert property (p_status) else $error("bad status");
property p_push; phase_execution && rd_data_valid && rd_data_ready &&
	exec_op == `OP_READ_DELETED && (rd_data_deleted || !skip_marked_sectors)
	|=> host_data_valid;
endproperty
a_push: assert property (p_push) else $error("byte lost");
property p_verify; phase_execution && exec_op == `OP_VERIFY |-> !host_data_valid;
endproperty
a_verify: assert property (p_verify) else $error("verify data");
endmodule // fdc_read_cmd_chk
bind fdc_read_cmd fdc_read_cmd_chk #(.VERSION_CODE(VERSION_CODE)) chk_u (.*);

/* dv/fdc_read_cmd_tb_top.sv */
// Purpose: Random and corner tests of the read/verify command interpreter
// Assumes: Host side driven on the falling edge
// Notes: Status and position bytes are derived from base
`timescale 1ns/1ps
module fdc_read_cmd_tb_top;
reg sys_clk = 1'b0;
reg rst_n = 1'b0;
reg cmd_valid = 1'b0;
reg [7:0] cmd_data = 8'h00;
reg host_data_ready = 1'b0;
reg res_rd = 1'b0;
reg slow = 1'b0;
reg [4:0] len = 5'h00;
reg [7:0] base = 8'h00;
wire cmd_ready, host_data_valid, res_valid, phase_command, phase_execution;
wire phase_result, exec_start, multitrack_flag, modulation_select;
wire skip_marked_sectors, count_enable_flag, head_select, drive_select_low;
wire drive_select_high, rd_data_valid, rd_data_deleted, rd_data_ready, rd_done;
wire [2:0] exec_op;
wire [7:0] host_data, res_data, id_cylinder, id_head, id_record, id_size;
wire [7:0] last_sector_number, gap_length, data_length_limit, sector_count;
wire [7:0] rd_data;
wire [7:0] result_status_0 = base;
wire [7:0] result_status_1 = base + 8'h01;
wire [7:0] result_status_2 = base + 8'h02;
wire [7:0] rd_cylinder = base + 8'h03;
wire [7:0] rd_head = base + 8'h04;
wire [7:0] rd_record = base + 8'h05;
wire [7:0] rd_size = base + 8'h06;
integer mismatches = 0;
integer samples_checked = 0;
integer cyc = 0;
reg [7:0] dq[$];
reg [7:0] p[0:8];
fdc_read_cmd #(.VERSION_CODE(8'h3c)) dut_u (.*);
fdc_read_path_model far_u (.*);
always #10 sys_clk = ~sys_clk;
task chk(input [7:0] got, input [7:0] exp);
	samples_checked = samples_checked + 1;
	if (got !== exp) begin
		mismatches = mismatches + 1;
		$display("unexpected at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task stop_test;
	$display("compared %0d mismatches %0d", samples_checked, mismatches);
	if (mismatches == 0 && samples_checked > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
function bit keep(input integer o, input bit s, input integer i);
	return o == 1 || (o == 0 && !(s && i % 2 == 0));
endfunction
task send(input [7:0] b);
	@(negedge sys_clk);
	cmd_valid = 1'b1;
	cmd_data = b;
	while (cmd_ready !== 1'b1)
		@(negedge sys_clk);
	@(posedge sys_clk);
endtask
// A long host stall first fills the buffer so its refusal can be seen
task collect(input integer n, input [7:0] r0, input integer hold);
	integer r, k;
	r = 0;
	k = 0;
	while (r < n) begin
		@(negedge sys_clk);
		k = k + 1;
		if (k == hold)
			chk({7'h0, rd_data_ready}, 8'h00);
		host_data_ready = k > hold && ($urandom & 1);
		res_rd = res_valid && ($urandom & 1);
		#5;
		if (host_data_valid && host_data_ready)
			chk(host_data, dq.size() > 0 ? dq.pop_front() : 8'hxx);
		if (res_rd) begin
			chk(res_data, r0 + 8'(r));
			r = r + 1;
		end
	end
	@(negedge sys_clk);
	res_rd = 1'b0;
	host_data_ready = 1'b0;
	chk(8'(dq.size()), 8'h00);
endtask
always @(posedge sys_clk) begin
	cyc = cyc + 1;
	if (cyc == 20000) begin
		mismatches = mismatches + 1;
		stop_test;
	end
end
initial begin : main
	integer t, i, n, o;
	void'($urandom(32'h9a99_efb8));
	repeat (3) @(negedge sys_clk);
	rst_n = 1'b1;
	for (t = 0; t < 40; t = t + 1) begin
		o = t < 6 ? t : $urandom % 6;
		len = t < 2 ? 5'h14 : 5'($urandom % 12);
		if (o == 2)
			len = 5'h00;
		base = 8'($urandom);
		slow = 1'($urandom);
		for (i = 0; i < 9; i = i + 1)
			p[i] = 8'($urandom);
		p[1] = p[1] & (o == 3 ? 8'h87 : 8'h07);
		case (o)
		0: p[0] = {p[0][7:6], p[0][5] | t == 0, 5'h0c};
		1: p[0] = {1'b0, p[0][6], 6'h02};
		2: p[0] = {1'b0, p[0][6], 6'h0a};
		3: p[0] = {p[0][7:5], 5'h16};
		4: p[0] = 8'h10;
		default: p[0] = 8'h1f;
		endcase
		n = o == 2 ? 2 : (o > 3 ? 1 : 9);
		dq.delete();
		for (i = 0; i < len; i = i + 1)
			if (keep(o, p[0][5], i))
				dq.push_back(base + 8'(i));
		for (i = 0; i < n; i = i + 1)
			send(p[i]);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		chk({7'h0, o < 4 ? phase_execution : res_valid}, 8'h01);
		chk({6'h0, phase_command, phase_result}, {7'h0, o > 3});
		collect(o < 4 ? 7 : 1, o < 4 ? base : (o == 4 ? 8'h3c : 8'h80),
			t == 1 ? 40 : 0);
		if (o < 4) begin
			chk({count_enable_flag, 4'h0, head_select, drive_select_high,
				drive_select_low}, p[1]);
			chk({multitrack_flag, modulation_select, skip_marked_sectors,
				5'h00}, p[0] & 8'he0);
		end
		if (o < 4 && o != 2) begin
			chk(id_cylinder, p[2]);
			chk(id_head, p[3]);
			chk(id_record, p[4]);
			chk(id_size, p[5]);
			chk(last_sector_number, p[6]);
			chk(gap_length, p[7]);
			chk(data_length_limit, p[8]);
			chk(sector_count, p[8]);
		end
	end
	stop_test;
end
endmodule // fdc_read_cmd_tb_top

/* dv/fdc_read_path_model.sv */
// Purpose: Behavioural disk read path behind the interpreter
// Assumes: An offered byte is held until taken
// Notes: Odd bytes carry the deleted mark; idle data is inverted
`timescale 1ns/1ps
module fdc_read_path_model (
	// Clock, reset and pacing
	input wire sys_clk,
	input wire rst_n,
	input wire slow,
	input wire [4:0] len,
	input wire [7:0] base,
	// Interpreter side
	input wire exec_start,
	input wire rd_data_ready,
	output reg rd_data_valid,
	output reg [7:0] rd_data,
	output wire rd_data_deleted,
	output reg rd_done
);
reg [4:0] idx;
reg [4:0] left;
reg busy;
reg pace;
assign rd_data_deleted = idx[0];
always @(posedge sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		rd_data_valid <= 1'b0;
		rd_data <= 8'h00;
		rd_done <= 1'b0;
		idx <= 5'h00;
		left <= 5'h00;
		busy <= 1'b0;
		pace <= 1'b0;
	end else begin
		pace <= ~pace;
		rd_done <= 1'b0;
		if (exec_start) begin
			busy <= 1'b1;
			left <= len;
			idx <= 5'h00;
		end else if (rd_data_valid) begin
			if (rd_data_ready) begin
				rd_data_valid <= 1'b0;
				rd_data <= ~rd_data;
				idx <= idx + 5'h01;
				left <= left - 5'h01;
			end
		end else if (busy && left != 5'h00 && (pace || !slow)) begin
			rd_data_valid <= 1'b1;
			rd_data <= base + {3'h0, idx};
		end else if (busy && left == 5'h00) begin
			busy <= 1'b0;
			rd_done <= 1'b1;
		end
	end
end
endmodule // fdc_read_path_model

/* hw/fdc_cmd_regs.vh */
// Purpose: Constants for the read/verify command interpreter
// Assumes: Command bytes arrive one per handshake on the data port
// Notes: Read deleted/verify patterns match the low five bits, read ID/track the low six with bit 7 clear; the version code all eight bits
`ifndef FDC_CMD_REGS_VH
`define FDC_CMD_REGS_VH

// Phase state encodings
`define PH_IDLE 3'h0
`define PH_PARAM 3'h1
`define PH_EXEC 3'h2
`define PH_DRAIN 3'h3
`define PH_RESULT 3'h4

// Internal operation codes; all but OP_VERSION and OP_INVALID can be driven to the read path
`define OP_NONE 3'h0
`define OP_READ_DELETED 3'h1
`define OP_READ_TRACK 3'h2
`define OP_READ_ID 3'h3
`define OP_VERIFY 3'h4
`define OP_VERSION 3'h5
`define OP_INVALID 3'h6

// Opcode patterns
`define CODE_READ_DELETED 5'b0_1100
`define CODE_VERIFY 5'b1_0110
`define CODE_READ_TRACK 6'b00_0010
`define CODE_READ_ID 6'b00_1010
`define CODE_VERSION 8'h10

// Field positions of the first two command bytes
`define BIT_MULTITRACK 7
`define BIT_MODULATION 6
`define BIT_SKIP 5
`define BIT_COUNT_EN 7
`define BIT_HEAD 2
`define BIT_DRIVE_HI 1
`define BIT_DRIVE_LO 0

// Byte counts per command
`define LEN_FULL 4'h9
`define LEN_READ_ID 4'h2
`define LEN_SINGLE 4'h1
`define RES_FULL 3'h7
`define RES_SINGLE 3'h1

`endif

/* hw/fdc_read_cmd.v */
// Purpose: Command decode and phase sequencing for read/verify commands
// Assumes: Host port and disk read path share sys_clk
// Notes: Results are presented only after the data FIFO has drained
`timescale 1ns/1ps
`include "fdc_cmd_regs.vh"

module fdc_read_cmd #(
	parameter [7:0] VERSION_CODE = 8'hA5, // Arbitrary value
	parameter [7:0] INVALID_CODE = 8'h80,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Host command byte port
	input wire cmd_valid,
	input wire [7:0] cmd_data,
	output wire cmd_ready,
	// Host data port for execution data
	output wire host_data_valid,
	output wire [7:0] host_data,
	input wire host_data_ready,
	// Host result port
	output wire res_valid,
	output reg [7:0] res_data,
	input wire res_rd,
	// Phase indication
	output wire phase_command,
	output wire phase_execution,
	output wire phase_result,
	// Operation request to the read path
	output reg exec_start,
	output reg [2:0] exec_op,
	output reg multitrack_flag,
	output reg modulation_select,
	output reg skip_marked_sectors,
	output reg count_enable_flag,
	output reg head_select,
	output reg drive_select_low,
	output reg drive_select_high,
	output wire [7:0] id_cylinder,
	output wire [7:0] id_head,
	output wire [7:0] id_record,
	output wire [7:0] id_size,
	output wire [7:0] last_sector_number,
	output wire [7:0] gap_length,
	output wire [7:0] data_length_limit,
	output wire [7:0] sector_count,
	// Sector data from the read path
	input wire rd_data_valid,
	input wire [7:0] rd_data,
	input wire rd_data_deleted,
	output wire rd_data_ready,
	// Completion from the read path
	input wire rd_done,
	input wire [7:0] result_status_0,
	input wire [7:0] result_status_1,
	input wire [7:0] result_status_2,
	input wire [7:0] rd_cylinder,
	input wire [7:0] rd_head,
	input wire [7:0] rd_record,
	input wire [7:0] rd_size
);
	reg [2:0] state;
	reg [2:0] next_state;
	reg [2:0] op;
	reg [3:0] cmd_len;
	reg [3:0] cmd_idx;
	reg [7:0] params [0:8];
	reg [7:0] results [0:6];
	reg [2:0] res_len;
	reg [2:0] res_idx;
	reg done_seen;
	reg [2:0] dec_op;
	reg [3:0] dec_len;
	wire cmd_take;
	wire last_byte;
	wire keep_byte;
	wire fifo_in_ready;
	wire fifo_in_valid;
	wire res_take;
	integer i;

	// Opcode decode of the first command byte
	always @* begin
		dec_op = `OP_INVALID;
		dec_len = `LEN_SINGLE;
		if (cmd_data == `CODE_VERSION) begin
			dec_op = `OP_VERSION;
			dec_len = `LEN_SINGLE;
		end else if (!cmd_data[7] && cmd_data[5:0] == `CODE_READ_ID) begin
			dec_op = `OP_READ_ID;
			dec_len = `LEN_READ_ID;
		end else if (!cmd_data[7] && cmd_data[5:0] == `CODE_READ_TRACK) begin
			dec_op = `OP_READ_TRACK;
			dec_len = `LEN_FULL;
		end else if (cmd_data[4:0] == `CODE_READ_DELETED) begin
			dec_op = `OP_READ_DELETED;
			dec_len = `LEN_FULL;
		end else if (cmd_data[4:0] == `CODE_VERIFY) begin
			dec_op = `OP_VERIFY;
			dec_len = `LEN_FULL;
		end
	end

	assign cmd_ready = (state == `PH_IDLE) || (state == `PH_PARAM);
	assign cmd_take = cmd_valid && cmd_ready;
	assign last_byte = (state == `PH_IDLE) ? (dec_len == `LEN_SINGLE)
		: (cmd_idx == cmd_len - 1'b1);
	assign res_valid = (state == `PH_RESULT);
	assign res_take = res_valid && res_rd;

	assign phase_command = cmd_ready;
	assign phase_execution = (state == `PH_EXEC) || (state == `PH_DRAIN);
	assign phase_result = res_valid;

	// Parameter bytes in the documented order
	assign id_cylinder = params[2];
	assign id_head = params[3];
	assign id_record = params[4];
	assign id_size = params[5];
	assign last_sector_number = params[6];
	assign gap_length = params[7];
	assign data_length_limit = params[8];
	assign sector_count = params[8];

	// Verify never hands data to the host; skip drops unwanted marks
	assign keep_byte = (op == `OP_READ_DELETED || op == `OP_READ_TRACK)
		&& !(op == `OP_READ_DELETED && skip_marked_sectors
		&& !rd_data_deleted);
	assign fifo_in_valid = (state == `PH_EXEC) && rd_data_valid && keep_byte;
	assign rd_data_ready = (state == `PH_EXEC)
		&& (keep_byte ? fifo_in_ready : 1'b1);

	fdc_sync_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_data(rd_data),
		.in_ready(fifo_in_ready),
		.out_valid(host_data_valid),
		.out_data(host_data),
		.out_ready(host_data_ready)
	);

	// Phase sequencing
	always @* begin
		next_state = state;
		case (state)
		`PH_IDLE: begin
			if (cmd_take && last_byte)
				next_state = `PH_RESULT;
			else if (cmd_take)
				next_state = `PH_PARAM;
		end
		`PH_PARAM: begin
			if (cmd_take && last_byte)
				next_state = `PH_EXEC;
		end
		`PH_EXEC: begin
			if (rd_done)
				next_state = `PH_DRAIN;
		end
		`PH_DRAIN: begin
			// Host must empty the FIFO before results appear
			if (!host_data_valid)
				next_state = `PH_RESULT;
		end
		`PH_RESULT: begin
			if (res_take && res_idx == res_len - 1'b1)
				next_state = `PH_IDLE;
		end
		default: next_state = `PH_IDLE;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= `PH_IDLE;
			op <= `OP_NONE;
			cmd_len <= `LEN_SINGLE;
			cmd_idx <= 4'h0;
			res_len <= `RES_SINGLE;
			res_idx <= 3'h0;
			done_seen <= 1'b0;
			res_data <= 8'h00;
			exec_start <= 1'b0;
			exec_op <= `OP_NONE;
			multitrack_flag <= 1'b0;
			modulation_select <= 1'b0;
			skip_marked_sectors <= 1'b0;
			count_enable_flag <= 1'b0;
			head_select <= 1'b0;
			drive_select_low <= 1'b0;
			drive_select_high <= 1'b0;
			for (i = 0; i < 9; i = i + 1)
				params[i] <= 8'h00;
			for (i = 0; i < 7; i = i + 1)
				results[i] <= 8'h00;
		end else begin
			state <= next_state;
			exec_start <= 1'b0;
			if (cmd_take) begin
				params[cmd_idx] <= cmd_data;
				cmd_idx <= last_byte ? 4'h0 : cmd_idx + 1'b1;
			end
			if (state == `PH_IDLE && cmd_take) begin
				op <= dec_op;
				cmd_len <= dec_len;
				done_seen <= 1'b0;
				// Only patterns that carry multitrack or skip latch them; modulation latches from every first byte
				multitrack_flag <= (dec_op == `OP_READ_DELETED
					|| dec_op == `OP_VERIFY) && cmd_data[`BIT_MULTITRACK];
				modulation_select <= cmd_data[`BIT_MODULATION];
				skip_marked_sectors <= (dec_op == `OP_READ_DELETED
					|| dec_op == `OP_VERIFY)
					&& cmd_data[`BIT_SKIP];
				if (dec_op == `OP_VERSION) begin
					results[0] <= VERSION_CODE;
					res_len <= `RES_SINGLE;
					res_idx <= 3'h0;
					res_data <= VERSION_CODE;
				end else if (dec_op == `OP_INVALID) begin
					// Unknown codes answer one status byte, no execution
					results[0] <= INVALID_CODE;
					res_len <= `RES_SINGLE;
					res_idx <= 3'h0;
					res_data <= INVALID_CODE;
				end
			end
			if (state == `PH_PARAM && cmd_take && cmd_idx == 4'h1) begin
				head_select <= cmd_data[`BIT_HEAD];
				drive_select_high <= cmd_data[`BIT_DRIVE_HI];
				drive_select_low <= cmd_data[`BIT_DRIVE_LO];
				count_enable_flag <= (op == `OP_VERIFY)
					&& cmd_data[`BIT_COUNT_EN];
			end
			if (state == `PH_PARAM && cmd_take && last_byte) begin
				exec_start <= 1'b1;
				exec_op <= op;
			end
			if (state == `PH_EXEC && rd_done && !done_seen) begin
				done_seen <= 1'b1;
				// Status then ID/position as reported at completion
				results[0] <= result_status_0;
				results[1] <= result_status_1;
				results[2] <= result_status_2;
				results[3] <= rd_cylinder;
				results[4] <= rd_head;
				results[5] <= rd_record;
				results[6] <= rd_size;
				res_len <= `RES_FULL;
				res_idx <= 3'h0;
				res_data <= result_status_0;
			end
			if (res_take && next_state == `PH_RESULT) begin
				res_idx <= res_idx + 1'b1;
				res_data <= results[res_idx + 3'h1];
			end
		end
	end
endmodule // fdc_read_cmd

/* hw/fdc_sync_fifo.v */
// Purpose: Synchronous FIFO between the disk read path and the host port
// Assumes: Single clock; push and pop may occur in the same cycle
// Notes: Full and empty are exact, derived from an occupancy count
`timescale 1ns/1ps
module fdc_sync_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// Fill side
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output wire in_ready,
	// Drain side
	output wire out_valid,
	output wire [WIDTH-1:0] out_data,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	integer i;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
					: rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // fdc_sync_fifo
